// [hw/adc_window_pkg.sv]
// constants for the converter control block with window comparator
package adc_window_pkg;
	// register indices: the bus byte address is four times the index
	localparam logic [7:0]  IDX_CHANNEL_SELECT = 8'hbb;
	localparam logic [7:0]  IDX_CONFIGURATION  = 8'hbc;
	localparam logic [7:0]  IDX_RESULT_LOW     = 8'hbe;
	localparam logic [7:0]  IDX_RESULT_HIGH    = 8'hbf;
	localparam logic [7:0]  IDX_ABOVE_LOW      = 8'hc4;
	localparam logic [7:0]  IDX_ABOVE_HIGH     = 8'hc5;
	localparam logic [7:0]  IDX_BELOW_HIGH     = 8'hc7;
	localparam logic [7:0]  IDX_BELOW_LOW      = 8'hce;
	localparam logic [7:0]  IDX_CONTROL        = 8'he8;
	localparam logic [7:0]  IDX_IRQ_STATUS     = 8'hf8;
	localparam logic [7:0]  IDX_IRQ_MASK       = 8'hf9;
	localparam int          ADDR_W             = 10;

	// control register fields
	localparam int          CTL_ENABLE_BIT     = 7;
	localparam int          CTL_START_BIT      = 4;
	localparam int          CTL_BUSY_BIT       = 3;
	localparam int          CTL_HIT_BIT        = 2;
	localparam int          CTL_TWELVE_BIT     = 1;
	localparam int          CTL_LJUST_BIT      = 0;

	// configuration register fields
	localparam int          CFG_CLKSEL_MSB     = 7;
	localparam int          CFG_CLKSEL_LSB     = 5;

	// status and mask bit positions
	localparam int          IRQ_DONE_BIT       = 0;
	localparam int          IRQ_WIN_BIT        = 1;

	// reset values
	localparam logic [7:0]  RST_CONFIGURATION  = 8'h60;
	localparam logic [7:0]  RST_BELOW_LOW      = 8'hff;
	localparam logic [7:0]  RST_ZERO           = 8'h00;

	// conversion length in conversion-clock periods
	localparam logic [4:0]  CONV_CLOCKS        = 5'h10;
	localparam logic [31:0] SLV_ZERO           = 32'h0000_0000;
endpackage

// [hw/divider_counter.sv]
// conversion clock prescaler: one-cycle tick every 1, 2, 4, 8 or 16 system clocks
`timescale 1ns/1ns
`default_nettype none
module divider_counter
	import adc_window_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// selection
	input  wire logic [2:0] sel,
	// output tick
	output logic            tick
);
	typedef struct packed {
		logic [3:0] count;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;
	logic [3:0] limit;

	// any code with its top bit set divides by sixteen
	always_comb begin
		case (sel)
			3'h0:    limit = 4'h0;
			3'h1:    limit = 4'h1;
			3'h2:    limit = 4'h3;
			3'h3:    limit = 4'h7;
			default: limit = 4'hf;
		endcase
		next_st = st;
		tick = (st.count >= limit);
		if (tick) begin
			next_st.count = 4'h0;
		end else begin
			next_st.count = st.count + 4'h1;
		end
	end

	// register the count, frozen while the enable is low
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// [hw/adc_window_compare_config.sv]
// converter control: registers, prescaler, conversion sequencing and window comparator
// Summary of operation
// - below above above threshold: hit only when result lies strictly between them
// - above above below: hit for results strictly outside, untouched between them
// - twelve-bit mode compares full result against high:low concatenated thresholds
// - in twelve-bit mode, left-justify cleared keeps results and thresholds right justified
// - conversion clock is system clock divided by 1,2,4,8,16; 1xx gives 16
// - eight-bit mode compares high bytes only, once at end of conversion
// - below-threshold low byte resets to all ones and is read/write
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module adc_window_compare_config
	import adc_window_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// analog core side
	input  wire logic [11:0] core_sample,
	output logic [7:0]       input_channel_select,
	output logic [2:0]       gain_sel,
	output logic             core_sample_strobe,
	// interrupt
	output logic             irq
);
	// ==================================================================
	// state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b10
	} conv_state_t;

	typedef struct packed {
		conv_state_t fsm;
		logic [4:0]  conv_count;
		logic [7:0]  chan;
		logic [7:0]  config_reg;
		logic [7:0]  control;
		logic [7:0]  result_low_byte;
		logic [7:0]  result_high_byte;
		logic [7:0]  above_threshold_low;
		logic [7:0]  above_threshold_high;
		logic [7:0]  below_threshold_low;
		logic [7:0]  below_threshold_high;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [31:0] rdata;
		logic        strobe;
		logic        ready_due; // first access cycle seen, answer in the next
	} blk_state_t;

	blk_state_t st;
	blk_state_t next_st;
	logic       conv_tick;
	logic       apb_access;
	logic       apb_wr;
	logic       apb_rd;
	logic       apb_first;
	logic [1:0] status_set;
	logic       addr_ok;
	logic [7:0] reg_index;
	logic [7:0] wbyte;
	logic [15:0] cmp_value;
	logic [15:0] below_thr;
	logic [15:0] above_thr;
	logic       win_hit;
	logic [11:0] sample;
	logic       twelve_bit;

	// ==================================================================
	// helpers
	// window decision shared by both widths
	function automatic logic window_test(input logic [15:0] val,
	                                     input logic [15:0] below,
	                                     input logic [15:0] above);
		if (below > above) begin
			window_test = (val < below) && (val > above);
		end else begin
			window_test = (val > above) || (val < below);
		end
	endfunction

	// the byte written, or the old value when its lane is not strobed
	function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] s,
	                                     input logic [7:0] old);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	// ==================================================================
	// prescaler
	// it runs free, so the first tick of a conversion comes within one divide period
	divider_counter u_div (
		.clk_sys (clk_sys),
		.srst    (srst),
		.clk_en  (clk_en),
		.sel     (st.config_reg[CFG_CLKSEL_MSB:CFG_CLKSEL_LSB]),
		.tick    (conv_tick)
	);

	// ==================================================================
	// apb decode: one wait state. the first access cycle captures read data, the second
	// answers with pready, and only that second cycle lets a write land, so a write never
	// takes effect twice; unmapped or misaligned addresses are refused with pslverr
	assign apb_first  = psel && penable && clk_en && !st.ready_due;
	assign apb_access = psel && penable && clk_en && st.ready_due;
	assign apb_wr     = apb_access && pwrite;
	assign apb_rd     = apb_first && !pwrite;
	assign reg_index  = paddr[ADDR_W-1:2];
	assign wbyte      = pwdata[7:0];

	// read-only registers accept a write and ignore it
	always_comb begin
		case (reg_index)
			IDX_CHANNEL_SELECT, IDX_CONFIGURATION, IDX_RESULT_LOW, IDX_RESULT_HIGH,
			IDX_ABOVE_LOW, IDX_ABOVE_HIGH, IDX_BELOW_HIGH, IDX_BELOW_LOW,
			IDX_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_MASK: addr_ok = (paddr[31:ADDR_W] == '0)
				&& (paddr[1:0] == 2'b00);
			default: addr_ok = 1'b0;
		endcase
	end

	// ==================================================================
	// comparator inputs; twelve-bit samples are right justified unless left-justify is set
	assign twelve_bit = st.control[CTL_TWELVE_BIT];
	// the core shares this clock and holds its sample settled until the completion cycle,
	// so it is read without resynchronisation
	assign sample     = core_sample;
	assign below_thr  = twelve_bit ? {st.below_threshold_high, st.below_threshold_low}
	                               : {8'h00, st.below_threshold_high};
	assign above_thr  = twelve_bit ? {st.above_threshold_high, st.above_threshold_low}
	                               : {8'h00, st.above_threshold_high};
	// thresholds are read in the same justification as the result
	assign cmp_value  = twelve_bit ? (st.control[CTL_LJUST_BIT] ? {sample, 4'h0}
	                                                            : {4'h0, sample})
	                               : {8'h00, sample[11:4]};
	assign win_hit    = window_test(cmp_value, below_thr, above_thr);

	// ==================================================================
	// hardware status sets, raised only in the completion cycle of a conversion;
	// kept apart so that a software clear in the same cycle cannot swallow them
	always_comb begin
		status_set               = 2'b00;
		status_set[IRQ_DONE_BIT] = (st.fsm == ST_DONE);
		status_set[IRQ_WIN_BIT]  = (st.fsm == ST_DONE) && win_hit;
	end

	// ==================================================================
	// next-state logic
	always_comb begin
		next_st = st;
		next_st.strobe = 1'b0;
		next_st.control[CTL_START_BIT] = 1'b0;
		// the wait state: armed by the first access cycle, dropped after the answer
		next_st.ready_due = psel && penable && !st.ready_due;

		// conversion sequencing on the prescaled tick
		case (st.fsm)
			ST_IDLE: begin
				next_st.control[CTL_BUSY_BIT] = 1'b0;
			end
			ST_CONV: begin
				// sixteen conversion-clock periods: the count moves only on the prescaled tick
				next_st.control[CTL_BUSY_BIT] = 1'b1;
				if (conv_tick) begin
					if (st.conv_count == CONV_CLOCKS - 5'h1) begin
						next_st.fsm    = ST_DONE;
						next_st.strobe = 1'b1;
					end else begin
						next_st.conv_count = st.conv_count + 5'h1;
					end
				end
			end
			ST_DONE: begin
				// latch the result and evaluate the window only at completion
				if (twelve_bit && !st.control[CTL_LJUST_BIT]) begin
					next_st.result_high_byte = {4'h0, sample[11:8]};
					next_st.result_low_byte  = sample[7:0];
				end else begin
					next_st.result_high_byte = sample[11:4];
					next_st.result_low_byte  = {sample[3:0], 4'h0};
				end
				next_st.irq_status[IRQ_DONE_BIT] = 1'b1;
				// the only place the flag is set; clearing is left to software
				if (win_hit) begin
					next_st.control[CTL_HIT_BIT]    = 1'b1;
					next_st.irq_status[IRQ_WIN_BIT] = 1'b1;
				end
				next_st.control[CTL_BUSY_BIT] = 1'b0;
				next_st.fsm = ST_IDLE;
			end
			default: begin
				next_st.fsm = ST_IDLE;
			end
		endcase

		// register writes; a hardware set in the same cycle wins over a clear
		if (apb_wr && addr_ok) begin
			case (reg_index)
				IDX_CHANNEL_SELECT: next_st.chan       = lane0(pwdata, pstrb, st.chan);
				IDX_CONFIGURATION:  next_st.config_reg = lane0(pwdata, pstrb, st.config_reg);
				IDX_ABOVE_LOW:  next_st.above_threshold_low  = lane0(pwdata, pstrb,
				                                               st.above_threshold_low);
				IDX_ABOVE_HIGH: next_st.above_threshold_high = lane0(pwdata, pstrb,
				                                               st.above_threshold_high);
				IDX_BELOW_HIGH: next_st.below_threshold_high = lane0(pwdata, pstrb,
				                                               st.below_threshold_high);
				IDX_BELOW_LOW:  next_st.below_threshold_low  = lane0(pwdata, pstrb,
				                                               st.below_threshold_low);
				IDX_CONTROL: begin
					if (pstrb[0]) begin
						next_st.control[CTL_ENABLE_BIT] = wbyte[CTL_ENABLE_BIT];
						next_st.control[CTL_TWELVE_BIT] = wbyte[CTL_TWELVE_BIT];
						next_st.control[CTL_LJUST_BIT]  = wbyte[CTL_LJUST_BIT];
						// only software clears the hit flag
						if (!wbyte[CTL_HIT_BIT] && !(st.fsm == ST_DONE && win_hit)) begin
							next_st.control[CTL_HIT_BIT] = 1'b0;
						end
						// a start while busy is ignored rather than restarting the conversion
						if (wbyte[CTL_START_BIT] && wbyte[CTL_ENABLE_BIT]
						    && st.fsm == ST_IDLE) begin
							next_st.fsm        = ST_CONV;
							next_st.conv_count = 5'h00;
							next_st.control[CTL_BUSY_BIT] = 1'b1;
						end
					end
				end
				IDX_IRQ_STATUS: begin
					if (pstrb[0]) begin
						// write one to clear; a set in the same cycle wins
						next_st.irq_status = (st.irq_status & ~wbyte[1:0]) | status_set;
					end
				end
				IDX_IRQ_MASK: begin
					if (pstrb[0]) begin
						next_st.irq_mask = wbyte[1:0];
					end
				end
				default: begin
					next_st.chan = st.chan;
				end
			endcase
		end

		// read data captured for the next cycle's holder; returned combinationally below
		next_st.rdata = SLV_ZERO;
		if (apb_rd && addr_ok) begin
			case (reg_index)
				IDX_CHANNEL_SELECT: next_st.rdata[7:0] = st.chan;
				IDX_CONFIGURATION:  next_st.rdata[7:0] = st.config_reg;
				IDX_RESULT_LOW:     next_st.rdata[7:0] = st.result_low_byte;
				IDX_RESULT_HIGH:    next_st.rdata[7:0] = st.result_high_byte;
				IDX_ABOVE_LOW:      next_st.rdata[7:0] = st.above_threshold_low;
				IDX_ABOVE_HIGH:     next_st.rdata[7:0] = st.above_threshold_high;
				IDX_BELOW_HIGH:     next_st.rdata[7:0] = st.below_threshold_high;
				IDX_BELOW_LOW:      next_st.rdata[7:0] = st.below_threshold_low;
				IDX_CONTROL:        next_st.rdata[7:0] = st.control;
				IDX_IRQ_STATUS:     next_st.rdata[1:0] = st.irq_status;
				IDX_IRQ_MASK:       next_st.rdata[1:0] = st.irq_mask;
				default:            next_st.rdata = SLV_ZERO;
			endcase
		end
	end

	// ==================================================================
	// state register; everything holds while the clock enable is low
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st                      <= '0;
			st.fsm                  <= ST_IDLE;
			st.config_reg           <= RST_CONFIGURATION;
			st.below_threshold_low  <= RST_BELOW_LOW;
			st.below_threshold_high <= RST_ZERO;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ==================================================================
	// outputs
	// pready rises in the second access cycle, when the registered read data stand;
	// an error is only ever reported together with the answer
	assign pready               = psel && penable && clk_en && st.ready_due;
	assign prdata               = st.rdata;
	assign pslverr              = pready && !addr_ok;
	assign input_channel_select = st.chan;
	assign gain_sel             = st.config_reg[2:0];
	assign core_sample_strobe   = st.strobe;
	assign irq                  = |(st.irq_status & st.irq_mask);
endmodule
`default_nettype wire

// [testbench/adc_window_properties.sv]
// concurrent properties for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_window_checker (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       srst,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic       pready,
	input wire logic       pslverr,
	// outputs under watch
	input wire logic [7:0] input_channel_select,
	input wire logic [2:0] gain_sel,
	input wire logic       core_sample_strobe,
	input wire logic       irq
);
	// ==========================================================
	// helpers: a write completes only where pready is sampled high
	wire wr_done = psel && penable && pready && pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable; endsequence
	// ==========================================================
	// bus timing: exactly one wait state
	wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("pready not on second access cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past transfer");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// ==========================================================
	// flags and settings only move by software or conversion
	hit_sticky_a: assert property ($fell(irq) |-> $past(wr_done))
		else $error("irq dropped without a write");
	irq_reset_a: assert property ($fell(srst) |-> !irq)
		else $error("irq set after reset");
	gain_write_a: assert property ($changed(gain_sel) |-> $past(wr_done))
		else $error("gain changed without a write");
	chan_write_a: assert property ($changed(input_channel_select) |-> $past(wr_done))
		else $error("channel changed without a write");
	strobe_pulse_a: assert property (core_sample_strobe |=> !core_sample_strobe)
		else $error("sample strobe longer than one cycle");
endmodule
`default_nettype wire
bind adc_window_compare_config adc_window_checker i_chk (
	.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .input_channel_select(input_channel_select),
	.gain_sel(gain_sel), .core_sample_strobe(core_sample_strobe), .irq(irq));

// [testbench/testbench.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import adc_window_pkg::*;
	// ==========================================================
	// signals
	logic        clk_sys     = 1'b0;
	logic        srst        = 1'b1;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [31:0] paddr       = 32'h0;
	logic [31:0] pwdata      = 32'h0;
	logic [11:0] core_sample = 12'h000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [7:0]  chan;
	logic [2:0]  gain;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        err;
	logic        lj          = 1'b0;
	int          miscompares = 0;
	int          checked     = 0;
	int          cyc         = 0;
	logic [11:0] corner [8]  = '{12'h000, 12'h0ff, 12'h100, 12'h101,
		12'h1ff, 12'h200, 12'h201, 12'hfff};
	// 25 MHz clock and a cycle count for timing the prescaler
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	adc_window_compare_config i_dut (
		.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_sample(core_sample),
		.input_channel_select(chan), .gain_sel(gain),
		.core_sample_strobe(), .irq(irq));
	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; read data and pready taken at the same edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	function automatic logic win(input logic [15:0] r, input logic [15:0] lt,
		input logic [15:0] gt);
		return (lt > gt) ? (r < lt && r > gt) : (r > gt || r < lt);
	endfunction
	// one conversion; polls the done flag, so the span is known to a few cycles
	task automatic run(input logic tw, input logic [11:0] s, input logic [15:0] lt,
		input logic [15:0] gt, input logic clr, output int dur);
		int t0;
		int n;
		n = 0;
		apb(1'b1, IDX_IRQ_STATUS, {6'h0, clr, 1'b1});
		core_sample <= s;
		apb(1'b1, IDX_BELOW_HIGH, lt[15:8]);
		apb(1'b1, IDX_BELOW_LOW, lt[7:0]);
		apb(1'b1, IDX_ABOVE_HIGH, gt[15:8]);
		apb(1'b1, IDX_ABOVE_LOW, gt[7:0]);
		t0 = cyc;
		apb(1'b1, IDX_CONTROL, {6'h24, tw, lj});
		rd = 32'h0;
		while (rd[IRQ_DONE_BIT] !== 1'b1 && n < 2000) begin
			apb(1'b0, IDX_IRQ_STATUS, 8'h00);
			n++;
		end
		if (n >= 2000)
			miscompares++;
		dur = cyc - t0;
	endtask
	// eight-bit samples are n*0x111 so either byte reading gives the same value
	task automatic conv(input logic tw, input logic [11:0] s, input logic [15:0] lt,
		input logic [15:0] gt);
		int d;
		logic e;
		e = tw ? win({4'h0, s}, lt, gt) : win({8'h0, s[7:0]}, {8'h0, lt[15:8]}, {8'h0, gt[15:8]});
		run(tw, s, lt, gt, 1'b1, d);
		check(rd[IRQ_WIN_BIT], e);
		if (tw) begin
			apb(1'b0, IDX_RESULT_HIGH, 8'h00);
			check(rd[7:0], {4'h0, s[11:8]});
			apb(1'b0, IDX_RESULT_LOW, 8'h00);
			check(rd[7:0], s[7:0]);
		end
	endtask
	task automatic results;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// watchdog: the sequence needs well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		results();
	end
	// main sequence
	initial begin
		int d;
		int d0;
		int dv;
		logic [15:0] lt;
		logic [15:0] gt;
		rd = $urandom(72932);
		d0 = 0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, IDX_CONFIGURATION, 8'h00);
		check(rd[7:0], 8'h60);
		check(err, 1'b0);
		apb(1'b0, IDX_BELOW_LOW, 8'h00);
		check(rd[7:0], 8'hff);
		apb(1'b1, IDX_BELOW_LOW, 8'h5a);
		apb(1'b0, IDX_BELOW_LOW, 8'h00);
		check(rd[7:0], 8'h5a);
		apb(1'b1, IDX_CONFIGURATION, 8'h05);
		check(gain, 3'h5);
		apb(1'b1, IDX_CHANNEL_SELECT, 8'h3c);
		check(chan, 8'h3c);
		apb(1'b0, 8'h00, 8'h00);
		check(err, 1'b1);
		// prescaler: each code stretches the conversion by its divide ratio
		for (int c = 0; c < 8; c++) begin
			dv = c[2] ? 16 : (1 << c[1:0]);
			apb(1'b1, IDX_CONFIGURATION, {c[2:0], 5'h00});
			run(1'b1, 12'h000, 16'h0, 16'h0, 1'b1, d);
			if (c == 0)
				d0 = d;
			check((d - d0 >= 15 * dv - 24) && (d - d0 <= 17 * dv - 8), 1'b1);
		end
		apb(1'b1, IDX_CONFIGURATION, 8'h00);
		// corners on both sides of each threshold, both orders
		for (int n = 0; n < 16; n++) begin
			conv(1'b0, 12'(n * 273), 16'h22a7, 16'h11c3);
			conv(1'b0, 12'(n * 273), 16'h11c3, 16'h22a7);
		end
		foreach (corner[i]) begin
			conv(1'b1, corner[i], 16'h0200, 16'h0100);
			conv(1'b1, corner[i], 16'h0100, 16'h0200);
		end
		// left-justified result: sample in the top twelve bits, thresholds alike
		lj = 1'b1;
		run(1'b1, 12'habc, 16'hac00, 16'hab00, 1'b1, d);
		check(rd[IRQ_WIN_BIT], win({12'habc, 4'h0}, 16'hac00, 16'hab00));
		apb(1'b0, IDX_RESULT_HIGH, 8'h00);
		check(rd[7:0], 8'hab);
		apb(1'b0, IDX_RESULT_LOW, 8'h00);
		check(rd[7:0], 8'hc0);
		lj = 1'b0;
		// random traffic; thresholds always differ in the high byte
		for (int n = 0; n < 24; n++) begin
			lt = 16'($urandom);
			gt = lt ^ {8'($urandom) | 8'h01, 8'($urandom)};
			d = $urandom;
			conv(n[0], n[0] ? 12'(d) : 12'(273 * (d & 15)), lt, gt);
		end
		// a hit stays flagged through a later miss
		conv(1'b1, 12'h180, 16'h0200, 16'h0100);
		run(1'b1, 12'h050, 16'h0200, 16'h0100, 1'b0, d);
		check(rd[IRQ_WIN_BIT], 1'b1);
		// interrupt: unmask, clear, mask off, done source
		apb(1'b1, IDX_IRQ_MASK, 8'h02);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1);
		apb(1'b1, IDX_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b0);
		apb(1'b1, IDX_IRQ_MASK, 8'h00);
		conv(1'b1, 12'h180, 16'h0200, 16'h0100);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b0);
		apb(1'b1, IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1);
		results();
	end
endmodule
`default_nettype wire
